// *** rtl/ppa_defines.svh ***
`ifndef PPA_DEFINES_SVH
`define PPA_DEFINES_SVH

// Clock period of i_mclk in ns (10 MHz).
`define PPA_CLK_PERIOD_NS 100
// Buffer delay between overload clearing early and brownout acting, in ms.
`define PPA_BUF_DELAY_MS 20
// Buffer delay in clock cycles, derived from the time and the clock rate.
`define PPA_BUF_DELAY_CYC ((`PPA_BUF_DELAY_MS * 1000000) / `PPA_CLK_PERIOD_NS)
// Width of the buffer delay counter.
`define PPA_CNT_W 18
// Owner codes, also the reset owner.
`define PPA_OWN_NONE 4'h1
`define PPA_OWN_ARE 4'h2
`define PPA_OWN_EBK 4'h4
`define PPA_OWN_BO 4'h8

`endif

// *** rtl/ppa_pkg.sv ***
package ppa_pkg;
	typedef enum logic [3:0] {
		PPA_IDLE = 4'h1,
		PPA_AUTO_RESTART = 4'h2,
		PPA_BLANKING = 4'h4,
		PPA_BROWNOUT = 4'h8
	} ppa_owner_t;
endpackage

// *** rtl/ppa_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for one level from outside the clock domain.
module ppa_sync (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Data
	input wire logic i_d,
	output logic o_q
);
	logic meta_r;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			meta_r <= 1'b0;
			o_q <= 1'b0;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule // ppa_sync

`default_nettype wire

// *** rtl/ppa_arbiter.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ppa_defines.svh"

module ppa_arbiter (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Requests from the sense-pin detectors (asynchronous levels)
	input wire logic i_are_req,
	input wire logic i_ebk_req,
	input wire logic i_bo_req,
	input wire logic i_ebk_done,
	input wire logic i_ovl_fault,
	// Arbitration result
	output logic [3:0] o_owner,
	output logic o_are_active,
	output logic o_ebk_active,
	output logic o_ebk_abort,
	output logic o_bo_active,
	output logic o_switch_en
);
	logic are_s, ebk_s, bo_s, done_s, ovl_s;
	ppa_pkg::ppa_owner_t owner_r, owner_nxt;
	logic bo_pend_r;
	logic ovl_early_r;
	logic ebk_end_r;
	logic buf_run_r;
	logic [`PPA_CNT_W-1:0] buf_cnt_r;
	logic buf_done;

	ppa_sync u_sync_are (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_are_req),
		.o_q(are_s)
	);
	ppa_sync u_sync_ebk (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_ebk_req),
		.o_q(ebk_s)
	);
	ppa_sync u_sync_bo (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_bo_req),
		.o_q(bo_s)
	);
	ppa_sync u_sync_done (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_ebk_done),
		.o_q(done_s)
	);
	ppa_sync u_sync_ovl (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_d(i_ovl_fault),
		.o_q(ovl_s)
	);

	assign buf_done = buf_run_r &&
		(buf_cnt_r == `PPA_CNT_W'(`PPA_BUF_DELAY_CYC - 1));

	// Owner selection by order of arrival, except that auto-restart takes over from a running blanking.
	always_comb begin
		owner_nxt = owner_r;
		case (owner_r)
			ppa_pkg::PPA_IDLE: begin
				// Same-cycle arrivals: auto-restart, then brownout, then blanking.
				if (are_s) begin
					owner_nxt = ppa_pkg::PPA_AUTO_RESTART;
				end else if (bo_s) begin
					owner_nxt = ppa_pkg::PPA_BROWNOUT;
				end else if (ebk_s) begin
					owner_nxt = ppa_pkg::PPA_BLANKING;
				end
			end
			ppa_pkg::PPA_AUTO_RESTART: begin
				// Later blanking or brownout requests are ignored.
				if (!are_s) begin
					owner_nxt = ppa_pkg::PPA_IDLE;
				end
			end
			ppa_pkg::PPA_BLANKING: begin
				if (are_s) begin
					owner_nxt = ppa_pkg::PPA_AUTO_RESTART;
				end else if (bo_pend_r && done_s && !ovl_s && !ovl_early_r) begin
					owner_nxt = ppa_pkg::PPA_BROWNOUT;
				end else if (bo_pend_r && ovl_early_r && buf_done &&
					(done_s || ebk_end_r)) begin
					owner_nxt = ppa_pkg::PPA_BROWNOUT;
				end else if (done_s && !bo_pend_r) begin
					owner_nxt = ppa_pkg::PPA_IDLE;
				end else if (!ebk_s && !done_s && !bo_pend_r) begin
					owner_nxt = ppa_pkg::PPA_IDLE;
				end
			end
			ppa_pkg::PPA_BROWNOUT: begin
				// Later auto-restart or blanking requests are ignored.
				if (!bo_s) begin
					owner_nxt = ppa_pkg::PPA_IDLE;
				end
			end
			default: begin
				owner_nxt = ppa_pkg::PPA_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			owner_r <= ppa_pkg::PPA_IDLE;
		end else begin
			owner_r <= owner_nxt;
		end
	end

	// A brownout arriving during blanking is held until blanking is over.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			bo_pend_r <= 1'b0;
		end else if (owner_r != ppa_pkg::PPA_BLANKING) begin
			bo_pend_r <= 1'b0;
		end else if (bo_s) begin
			bo_pend_r <= 1'b1;
		end else if (done_s) begin
			bo_pend_r <= 1'b0;
		end
	end

	// Overload cleared while blanking still ran with brownout pending.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ovl_early_r <= 1'b0;
		end else if (owner_r != ppa_pkg::PPA_BLANKING) begin
			ovl_early_r <= 1'b0;
		end else if (bo_pend_r && !ovl_s && !done_s) begin
			ovl_early_r <= 1'b1;
		end
	end

	// The end of blanking is remembered, as the end strobe may be a short
	// pulse and a finished buffer must not cut a running blanking short.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ebk_end_r <= 1'b0;
		end else if (owner_r != ppa_pkg::PPA_BLANKING) begin
			ebk_end_r <= 1'b0;
		end else if (done_s) begin
			ebk_end_r <= 1'b1;
		end
	end

	// Buffer timer; it runs from the early clear regardless of the blanking
	// end, so the buffer is measured from the moment the fault went away.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			buf_run_r <= 1'b0;
			buf_cnt_r <= '0;
		end else if (!ovl_early_r || owner_r != ppa_pkg::PPA_BLANKING) begin
			buf_run_r <= 1'b0;
			buf_cnt_r <= '0;
		end else if (!buf_done) begin
			buf_run_r <= 1'b1;
			buf_cnt_r <= buf_run_r ? buf_cnt_r + 1'b1 : buf_cnt_r;
		end
	end

	// Outputs are registered from the next owner, so they change on the
	// same edge as the owner register and never lag it.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_owner <= `PPA_OWN_NONE;
		end else begin
			o_owner <= owner_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_are_active <= 1'b0;
		end else begin
			o_are_active <= owner_nxt == ppa_pkg::PPA_AUTO_RESTART;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_ebk_active <= 1'b0;
		end else begin
			o_ebk_active <= owner_nxt == ppa_pkg::PPA_BLANKING;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_ebk_abort <= 1'b0;
		end else begin
			o_ebk_abort <= owner_r == ppa_pkg::PPA_BLANKING &&
				owner_nxt == ppa_pkg::PPA_AUTO_RESTART;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_bo_active <= 1'b0;
		end else begin
			o_bo_active <= owner_nxt == ppa_pkg::PPA_BROWNOUT;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_switch_en <= 1'b1;
		end else begin
			o_switch_en <= owner_nxt != ppa_pkg::PPA_BROWNOUT;
		end
	end
endmodule // ppa_arbiter

`default_nettype wire

// *** verification/ppa_arbiter_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppa_arbiter_chk (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Watched ports
	input wire logic i_ovl_fault,
	input wire logic [3:0] o_owner,
	input wire logic o_are_active,
	input wire logic o_ebk_active,
	input wire logic o_ebk_abort,
	input wire logic o_bo_active,
	input wire logic o_switch_en
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	property p_are_hold; o_are_active |=> !o_ebk_active; endproperty
	a_are_hold: assert property (p_are_hold) else $error("ebk over ar");
	property p_abort; o_ebk_abort |-> o_are_active && $past(o_ebk_active);
	endproperty
	a_abort: assert property (p_abort) else $error("bad abort");
	property p_abort_one; o_ebk_abort |=> !o_ebk_abort; endproperty
	a_abort_one: assert property (p_abort_one) else $error("long abort");
	// Overload must have been clear before blanking hands over to brownout;
	// the pin sample behind that decision lies three edges back.
	property p_bo_after;
		o_bo_active && $past(o_ebk_active) |-> !$past(i_ovl_fault, 3);
	endproperty
	a_bo_after: assert property (p_bo_after) else $error("early bo");
	property p_bo_ar; o_bo_active |=> !o_are_active; endproperty
	a_bo_ar: assert property (p_bo_ar) else $error("ar over bo");
	property p_bo_ebk; o_bo_active |=> !o_ebk_active; endproperty
	a_bo_ebk: assert property (p_bo_ebk) else $error("ebk over bo");
	property p_decode; o_owner == 4'h8 |-> o_bo_active && !o_ebk_active;
	endproperty
	a_decode: assert property (p_decode) else $error("bad decode");
	property p_sw_off; o_bo_active |-> !o_switch_en; endproperty
	a_sw_off: assert property (p_sw_off) else $error("switch in bo");
	property p_sw_on; !o_bo_active |-> o_switch_en; endproperty
	a_sw_on: assert property (p_sw_on) else $error("switch off");
endmodule // ppa_arbiter_chk
bind ppa_arbiter ppa_arbiter_chk u_chk (.i_mclk, .i_rst, .i_ovl_fault,
	.o_owner, .o_are_active, .o_ebk_active, .o_ebk_abort, .o_bo_active,
	.o_switch_en);
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic i_mclk = 1'b0, i_rst = 1'b1;
	logic are = 1'b0, ebk = 1'b0, bo = 1'b0, done = 1'b0, ovl = 1'b0;
	logic [3:0] o_owner;
	logic o_are, o_ebk, o_abort, o_bo, o_sw;
	int failures = 0, n_tests = 0;
	ppa_arbiter dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_are_req(are),
		.i_ebk_req(ebk), .i_bo_req(bo), .i_ebk_done(done),
		.i_ovl_fault(ovl), .o_owner(o_owner), .o_are_active(o_are),
		.o_ebk_active(o_ebk), .o_ebk_abort(o_abort), .o_bo_active(o_bo),
		.o_switch_en(o_sw));
	initial forever #50 i_mclk = ~i_mclk;
	// Called on a rising edge; six edges cover the two synchroniser stages
	// and the output register with room to spare.
	task put(input logic [4:0] v);
		{are, ebk, bo, done, ovl} <= v;
		repeat (6) @(posedge i_mclk);
	endtask
	// Both compares read the ports at the falling edge, where they have
	// settled, and return on the next rising edge.
	task chk_own(input logic [3:0] exp);
		@(negedge i_mclk);
		n_tests++;
		if (o_owner !== exp) begin
			failures++;
			$display("CHECK FAILED o_owner exp %h got %h", exp, o_owner);
		end
		@(posedge i_mclk);
	endtask
	// Flags in order: auto-restart, blanking, abort, brownout, switch enable.
	task chk_flags(input logic [4:0] exp);
		logic [4:0] got;
		@(negedge i_mclk);
		got = {o_are, o_ebk, o_abort, o_bo, o_sw};
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED flags exp %h got %h", exp, got);
		end
		@(posedge i_mclk);
	endtask
	task rst;
		i_rst <= 1'b1;
		{are, ebk, bo, done, ovl} <= 5'h00;
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		chk_flags(5'h01);
	endtask
	task t_r1;
		rst;
		put(5'h10);
		put(5'h18);
		chk_own(4'h2);
		chk_flags(5'h11);
	endtask
	// The abort pulse stands for one cycle, three edges after the request.
	task t_r2;
		rst;
		put(5'h08);
		chk_own(4'h4);
		{are, ebk, bo, done, ovl} <= 5'h18;
		repeat (3) @(posedge i_mclk);
		chk_flags(5'h15);
		chk_own(4'h2);
		chk_flags(5'h11);
	endtask
	task t_r6;
		rst;
		put(5'h04);
		put(5'h14);
		chk_own(4'h8);
		chk_flags(5'h02);
		put(5'h00);
		chk_flags(5'h01);
	endtask
	task t_r7;
		rst;
		put(5'h04);
		put(5'h0c);
		chk_own(4'h8);
		rst;
		put(5'h10);
		put(5'h14);
		chk_own(4'h2);
	endtask
	task t_r34;
		rst;
		put(5'h09);
		put(5'h0d);
		chk_own(4'h4);
		put(5'h0e);
		chk_own(4'h8);
		chk_flags(5'h02);
	endtask
	// The full buffer is far too long to run out here; this only shows
	// that brownout is held off after an early overload clear.
	task t_r5;
		rst;
		put(5'h09);
		put(5'h0d);
		put(5'h0c);
		put(5'h0e);
		repeat (50) @(posedge i_mclk);
		chk_own(4'h4);
		chk_flags(5'h09);
	endtask
	task end_sim;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		t_r1;
		t_r2;
		t_r6;
		t_r7;
		t_r34;
		t_r5;
		end_sim;
	end
	// About 255 cycles are needed; this cuts a hang short.
	initial begin
		repeat (2000) @(posedge i_mclk);
		failures++;
		end_sim;
	end
endmodule // tb
`default_nettype wire
